// ### verilog/gpbcd_pkg.sv
// constants shared by the port block: register map, fields, reset values
package gpbcd_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_SECOND_DATA = 8'h06;
  localparam logic [7:0] ADDR_THIRD_DATA = 8'h07;
  localparam logic [7:0] ADDR_FOURTH_DATA = 8'h08;
  localparam logic [7:0] ADDR_TIMER_PULLUP_CFG = 8'h81;
  localparam logic [7:0] ADDR_SECOND_DIR = 8'h86;
  localparam logic [7:0] ADDR_THIRD_DIR = 8'h87;
  localparam logic [7:0] ADDR_FOURTH_DIR = 8'h88;
  localparam logic [7:0] ADDR_FIFTH_DIR_SLAVE = 8'h89;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0B;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h8B;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] CFG_RESET = 8'hFF;
  localparam logic [7:0] FIFTH_RESET = 8'h07;
  localparam logic [7:0] FIFTH_WR_MASK = 8'h17;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int PULLUP_N_BIT = 7;
  localparam int SLAVE_MODE_BIT = 4;
  localparam int CHANGE_FLAG_BIT = 0;
  localparam int EXT_IRQ_BIT = 1;
  localparam int EXT_PIN_BIT = 0;
  localparam int CHANGE_LO = 4;
  localparam int CHANGE_HI = 7;
  localparam int PROG_CLK_BIT = 6;
  localparam int PROG_DATA_BIT = 7;
  localparam logic [1:0] IRQ_USED = 2'h3;
endpackage : gpbcd_pkg

// ### verilog/gpbcd_pin_if.sv
// interface carrying one 8-bit port's pin signals between the top and a pin slice
`timescale 1ns/10ps
interface gpbcd_pin_if;
  logic [7:0] latch;
  logic [7:0] dir;
  logic [7:0] ovrEn;
  logic [7:0] ovrDir;
  logic [7:0] ovrOut;
  logic [7:0] padIn;
  logic [7:0] padOut;
  logic [7:0] padOe;
  logic [7:0] level;
  modport slice (input latch, dir, ovrEn, ovrDir, ovrOut, padIn, output padOut, padOe, level);
  modport top (output latch, dir, ovrEn, ovrDir, ovrOut, padIn, input padOut, padOe, level);
endinterface : gpbcd_pin_if

// ### verilog/gpbcd_pin_slice.sv
// one 8-bit port: pin synchroniser, direction override and output driver
`timescale 1ns/10ps
module gpbcd_pin_slice
  import gpbcd_pkg::*;
(
  input wire logic clk,
  gpbcd_pin_if.slice pins
);
  logic [7:0] syncA;
  logic [7:0] syncB;
  logic [7:0] effDir;

  // two stages before anything reads the pins
  always_ff @(posedge clk) begin
    syncA <= pins.padIn;
    syncB <= syncA;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      effDir[i] = pins.ovrEn[i] ? pins.ovrDir[i] : pins.dir[i];
      pins.padOut[i] = pins.ovrEn[i] ? pins.ovrOut[i] : pins.latch[i];
    end
  end

  assign pins.padOe = ~effDir;
  assign pins.level = syncB;
endmodule : gpbcd_pin_slice

// ### verilog/gpbcd_ports.sv
// top of the three general purpose ports with register port and change interrupt
// Operation
// (RULE1) third port is 8 bits, each pin with its own direction bit
// (RULE2) enabled peripheral forces pin direction regardless of software direction bit
// (RULE3) third port pins routed to timer, capture/compare, serial and uart functions
// (RULE4) fourth port is 8 bits, each pin individually input or output
// (RULE5) slave mode bit set hands fourth port to the parallel slave port
// (RULE6) second port pins 4..7 carry change-detect interrupt
// (RULE7) second port pin 0 doubles as external interrupt input
// (RULE8) every second port pin has a software controlled weak pull-up
// (RULE9) second port pins 6 and 7 serve serial programming clock and data
// (RULE10) all direction bits reset to one, pins start as inputs
// (RULE11) data latches keep contents across reset, undefined at power-on
// (RULE12) direction one floats the driver, zero drives the latch value
// (RULE13) data read returns pin levels, write updates output latch
// (RULE14) change inputs compared to values latched at last read, flag set; the code also re-latches them on a write of the second port data
// (RULE15) pull-up bit low enables pull-ups except on output pins
`timescale 1ns/10ps
module gpbcd_ports
  import gpbcd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdData,
  output logic irq,
  input wire logic [7:0] secondPadIn,
  output logic [7:0] secondPadOut,
  output logic [7:0] secondPadOe,
  output logic [7:0] secondPullupEn,
  input wire logic [7:0] thirdPadIn,
  output logic [7:0] thirdPadOut,
  output logic [7:0] thirdPadOe,
  input wire logic [7:0] fourthPadIn,
  output logic [7:0] fourthPadOut,
  output logic [7:0] fourthPadOe,
  input wire logic [7:0] periphEn,
  input wire logic [7:0] periphDir,
  input wire logic [7:0] periphOut,
  output logic [7:0] periphIn,
  input wire logic slaveDriveEn,
  input wire logic [7:0] slaveOut,
  output logic slaveModeSelect,
  output logic [7:0] fourthLatch,
  output logic externalInterruptPin,
  output logic progClock,
  output logic progData
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] secondLatch;
  logic [7:0] thirdLatch;
  logic [7:0] secondDir;
  logic [7:0] thirdDir;
  logic [7:0] fourthDir;
  logic [7:0] timerPullupCfg;
  logic [7:0] fifthDirSlave;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  logic [3:0] changeSnapshot;
  logic extPrev;
  logic [7:0] secondLevel;
  logic [7:0] thirdLevel;
  logic [7:0] fourthLevel;
  logic changeMismatch;
  logic extEdge;
  logic changeFlag;
  logic extFlag;
  logic changeClear;
  logic extClear;
  logic [7:0] next_rdData;

  gpbcd_pin_if secondPins();
  gpbcd_pin_if thirdPins();
  gpbcd_pin_if fourthPins();

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  function automatic logic [7:0] rmw(input logic [7:0] pinLevel);
    rmw = pinLevel;
  endfunction : rmw

  ////////////////////////////////////////////////////////////////////////////
  // pin slices
  assign secondPins.latch = secondLatch;
  assign secondPins.dir = secondDir; // [RULE12]
  assign secondPins.ovrEn = 8'h00;
  assign secondPins.ovrDir = 8'h00;
  assign secondPins.ovrOut = 8'h00;
  assign secondPins.padIn = secondPadIn;
  gpbcd_pin_slice secondSlice (.clk(clk), .pins(secondPins.slice));

  // peripheral override of third port direction and data
  assign thirdPins.latch = thirdLatch;
  assign thirdPins.dir = thirdDir; // [RULE1]
  assign thirdPins.ovrEn = periphEn; // [RULE2] [RULE3]
  assign thirdPins.ovrDir = periphDir; // [RULE2]
  assign thirdPins.ovrOut = periphOut; // [RULE3]
  assign thirdPins.padIn = thirdPadIn;
  gpbcd_pin_slice thirdSlice (.clk(clk), .pins(thirdPins.slice));

  // in slave mode the direction register is ignored; the external master steers it
  assign slaveModeSelect = fifthDirSlave[SLAVE_MODE_BIT];
  assign fourthPins.latch = fourthLatch;
  assign fourthPins.dir = fourthDir; // [RULE4]
  assign fourthPins.ovrEn = {8{slaveModeSelect}}; // [RULE5]
  assign fourthPins.ovrDir = {8{~slaveDriveEn}}; // [RULE5]
  assign fourthPins.ovrOut = slaveOut; // [RULE5]
  assign fourthPins.padIn = fourthPadIn;
  gpbcd_pin_slice fourthSlice (.clk(clk), .pins(fourthPins.slice));

  assign secondLevel = secondPins.level;
  assign thirdLevel = thirdPins.level;
  assign fourthLevel = fourthPins.level;
  assign secondPadOut = secondPins.padOut;
  assign secondPadOe = secondPins.padOe;
  assign thirdPadOut = thirdPins.padOut;
  assign thirdPadOe = thirdPins.padOe;
  assign fourthPadOut = fourthPins.padOut;
  assign fourthPadOe = fourthPins.padOe;
  assign periphIn = thirdLevel; // [RULE3]
  assign externalInterruptPin = secondLevel[EXT_PIN_BIT]; // [RULE7]
  assign progClock = secondLevel[PROG_CLK_BIT]; // [RULE9]
  assign progData = secondLevel[PROG_DATA_BIT]; // [RULE9]

  // pull-ups off on any output pin
  assign secondPullupEn = {8{~timerPullupCfg[PULLUP_N_BIT]}} & secondDir; // [RULE8] [RULE15]

  ////////////////////////////////////////////////////////////////////////////
  // data latches take no reset so they survive every reset
  always_ff @(posedge clk) begin
    if (regWrite && hit(regAddr, ADDR_SECOND_DATA)) begin
      secondLatch <= regWrData; // [RULE11] [RULE13]
    end
  end

  always_ff @(posedge clk) begin
    if (regWrite && hit(regAddr, ADDR_THIRD_DATA)) begin
      thirdLatch <= regWrData; // [RULE11] [RULE13]
    end
  end

  always_ff @(posedge clk) begin
    if (regWrite && hit(regAddr, ADDR_FOURTH_DATA)) begin
      fourthLatch <= regWrData; // [RULE11] [RULE13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // direction and configuration registers
  always_ff @(posedge clk) begin
    if (reset) begin
      secondDir <= DIR_RESET; // [RULE10]
      thirdDir <= DIR_RESET; // [RULE10]
      fourthDir <= DIR_RESET; // [RULE10]
      timerPullupCfg <= CFG_RESET;
      fifthDirSlave <= FIFTH_RESET;
      irqMask <= 2'(MASK_RESET);
    end else if (regWrite) begin
      if (hit(regAddr, ADDR_SECOND_DIR)) begin
        secondDir <= regWrData;
      end
      if (hit(regAddr, ADDR_THIRD_DIR)) begin
        thirdDir <= regWrData;
      end
      if (hit(regAddr, ADDR_FOURTH_DIR)) begin
        fourthDir <= regWrData;
      end
      if (hit(regAddr, ADDR_TIMER_PULLUP_CFG)) begin
        timerPullupCfg <= regWrData;
      end
      if (hit(regAddr, ADDR_FIFTH_DIR_SLAVE)) begin
        fifthDirSlave <= regWrData & FIFTH_WR_MASK; // [RULE5]
      end
      if (hit(regAddr, ADDR_IRQ_MASK)) begin
        irqMask <= regWrData[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // change detect; any read or write of the second port data register re-arms the snapshot
  always_ff @(posedge clk) begin
    if (reset) begin
      changeSnapshot <= 4'h0;
    end else if ((regRead || regWrite) && hit(regAddr, ADDR_SECOND_DATA)) begin
      changeSnapshot <= secondLevel[CHANGE_HI:CHANGE_LO]; // [RULE14]
    end
  end

  // output pins are left out of the comparison
  assign changeMismatch = |((secondLevel[CHANGE_HI:CHANGE_LO] ^ changeSnapshot)
                            & secondDir[CHANGE_HI:CHANGE_LO]); // [RULE6] [RULE14]

  // tracks the pin through reset too, so a pin already high at release gives no false edge
  always_ff @(posedge clk) begin
    extPrev <= secondLevel[EXT_PIN_BIT];
  end

  assign extEdge = secondLevel[EXT_PIN_BIT] & ~extPrev; // [RULE7]

  // set beats write-one-to-clear; a standing mismatch keeps re-setting the flag
  assign changeClear = regWrite && hit(regAddr, ADDR_IRQ_STATUS) && regWrData[CHANGE_FLAG_BIT];
  assign extClear = regWrite && hit(regAddr, ADDR_IRQ_STATUS) && regWrData[EXT_IRQ_BIT];

  always_ff @(posedge clk) begin
    if (reset) begin
      changeFlag <= 1'b0;
    end else if (changeMismatch) begin
      changeFlag <= 1'b1; // [RULE14]
    end else if (changeClear) begin
      changeFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      extFlag <= 1'b0;
    end else if (extEdge) begin
      extFlag <= 1'b1; // [RULE7]
    end else if (extClear) begin
      extFlag <= 1'b0;
    end
  end

  always_comb begin
    irqStatus = 2'h0;
    irqStatus[CHANGE_FLAG_BIT] = changeFlag;
    irqStatus[EXT_IRQ_BIT] = extFlag;
  end

  assign irq = |(irqStatus & irqMask & IRQ_USED);

  ////////////////////////////////////////////////////////////////////////////
  // read path; data registers show pin levels, not latches
  always_comb begin
    next_rdData = 8'h00;
    case (regAddr)
      ADDR_SECOND_DATA: next_rdData = rmw(secondLevel); // [RULE13]
      ADDR_THIRD_DATA: next_rdData = rmw(thirdLevel); // [RULE13]
      ADDR_FOURTH_DATA: next_rdData = rmw(fourthLevel); // [RULE13]
      ADDR_TIMER_PULLUP_CFG: next_rdData = timerPullupCfg;
      ADDR_SECOND_DIR: next_rdData = secondDir;
      ADDR_THIRD_DIR: next_rdData = thirdDir;
      ADDR_FOURTH_DIR: next_rdData = fourthDir;
      ADDR_FIFTH_DIR_SLAVE: next_rdData = fifthDirSlave;
      ADDR_IRQ_STATUS: next_rdData = {6'h00, irqStatus};
      ADDR_IRQ_MASK: next_rdData = {6'h00, irqMask};
      default: next_rdData = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= next_rdData;
    end else begin
      regRdData <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_in_reset;
    reset;
  endsequence
  sequence s_dirs_inputs;
    secondDir == DIR_RESET && thirdDir == DIR_RESET && fourthDir == DIR_RESET;
  endsequence
  sequence s_change_seen;
    changeMismatch;
  endsequence
  sequence s_ext_rise;
    !secondLevel[EXT_PIN_BIT] ##1 secondLevel[EXT_PIN_BIT];
  endsequence
  sequence s_second_access;
    (regRead || regWrite) && regAddr == ADDR_SECOND_DATA;
  endsequence

  // reset values
  a_dir_reset: assert property (@(posedge clk) s_in_reset |=> s_dirs_inputs) // [RULE10]
    else $error("direction not all ones after reset");
  a_cfg_reset: assert property (@(posedge clk) s_in_reset |=> // [RULE15]
    (timerPullupCfg == CFG_RESET && fifthDirSlave == FIFTH_RESET && irqMask == 2'h0))
    else $error("configuration not at reset value");

  // pin drive; undriven pins are masked so an unwritten latch does not count
  a_third_dir: assert property (@(posedge clk) disable iff (reset) // [RULE2]
    thirdPadOe == ~((periphEn & periphDir) | (~periphEn & thirdDir)))
    else $error("third port drive enable wrong");
  a_third_route: assert property (@(posedge clk) disable iff (reset) // [RULE3]
    ((thirdPadOut ^ periphOut) & periphEn & ~periphDir) == 8'h00)
    else $error("peripheral output not routed");
  a_dir_write: assert property (@(posedge clk) disable iff (reset) // [RULE1]
    (regWrite && regAddr == ADDR_THIRD_DIR) |=> thirdDir == $past(regWrData))
    else $error("third direction not written");
  a_fourth_dir: assert property (@(posedge clk) disable iff (reset) // [RULE4] [RULE12]
    !slaveModeSelect |-> (fourthPadOe == ~fourthDir
    && ((fourthPadOut ^ fourthLatch) & fourthPadOe) == 8'h00))
    else $error("fourth port drive wrong");
  a_second_drive: assert property (@(posedge clk) disable iff (reset) // [RULE12]
    secondPadOe == ~secondDir && ((secondPadOut ^ secondLatch) & secondPadOe) == 8'h00)
    else $error("second port drive wrong");
  a_slave_mode: assert property (@(posedge clk) disable iff (reset) // [RULE5]
    slaveModeSelect |-> (fourthPadOe == {8{slaveDriveEn}} && fourthPadOut == slaveOut))
    else $error("slave mode drive wrong");
  a_fifth_mask: assert property (@(posedge clk) (fifthDirSlave & ~FIFTH_WR_MASK) == 8'h00) // [RULE5]
    else $error("unimplemented fifth register bit set");

  // pull-ups
  a_pullup_gate: assert property (@(posedge clk) disable iff (reset) // [RULE15]
    timerPullupCfg[PULLUP_N_BIT] |-> secondPullupEn == 8'h00)
    else $error("pull-up on while disabled");
  a_pullup_out: assert property (@(posedge clk) disable iff (reset) // [RULE15]
    (secondPullupEn & ~secondDir) == 8'h00)
    else $error("pull-up on an output pin");

  // interrupt flags, second latch write and idle read data
  a_change_flag: assert property (@(posedge clk) disable iff (reset) s_change_seen |=> changeFlag) // [RULE14]
    else $error("change flag not set");
  a_change_rearm: assert property (@(posedge clk) disable iff (reset) // [RULE14]
    s_second_access |=> changeSnapshot == $past(secondLevel[CHANGE_HI:CHANGE_LO]))
    else $error("change snapshot not taken");
  a_change_clear: assert property (@(posedge clk) disable iff (reset) // [RULE14]
    (changeClear && !changeMismatch) |=> !changeFlag)
    else $error("change flag not cleared");
  a_latch_write: assert property (@(posedge clk) disable iff (reset) // [RULE13]
    (regWrite && regAddr == ADDR_SECOND_DATA) |=> secondLatch == $past(regWrData))
    else $error("second latch not written");
  a_ext_flag: assert property (@(posedge clk) disable iff (reset) s_ext_rise |=> extFlag) // [RULE7]
    else $error("external interrupt flag not set");
  a_ext_clear: assert property (@(posedge clk) disable iff (reset) // [RULE7]
    (extClear && !extEdge) |=> !extFlag)
    else $error("external interrupt flag not cleared");
  a_irq_out: assert property (@(posedge clk) disable iff (reset) // [RULE6]
    (irqStatus & irqMask) != 2'h0 |-> irq)
    else $error("interrupt not raised");
  a_irq_low: assert property (@(posedge clk) disable iff (reset) // [RULE6]
    (irqStatus & irqMask) == 2'h0 |-> !irq)
    else $error("interrupt raised with nothing pending");
  a_rd_idle: assert property (@(posedge clk) disable iff (reset) // [RULE13]
    !regRead |=> regRdData == 8'h00)
    else $error("read data outside its cycle");
endmodule : gpbcd_ports

// ### test/gpbcd_pin_world.sv
// external circuitry on one 8-bit port: drivers, pull-ups and floating pins
`timescale 1ns/10ps
module gpbcd_pin_world (
  input wire logic clk,
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOe,
  input wire logic [7:0] pullEn,
  input wire logic [7:0] extEn,
  input wire logic [7:0] extVal,
  output logic [7:0] padIn
);
  // an undriven pin must not look stable, so it wanders every cycle
  logic [7:0] floatPat = 8'h5A;
  always_ff @(posedge clk) begin
    floatPat <= ~floatPat;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (padOe[i]) begin
        padIn[i] = padOut[i];
      end else if (extEn[i]) begin
        padIn[i] = extVal[i];
      end else if (pullEn[i]) begin
        padIn[i] = 1'b1;
      end else begin
        padIn[i] = floatPat[i];
      end
    end
  end
endmodule : gpbcd_pin_world

// ### test/tb.sv
// self-checking bench for the three general purpose ports
`timescale 1ns/10ps
module tb
  import gpbcd_pkg::*;
;
  logic clk, reset, regWrite, regRead, irq, slaveDriveEn, slaveModeSelect;
  logic extIrqPin, progClock, progData;
  logic [7:0] regAddr, regWrData, regRdData, rdv, ext2Val, fourthLatch;
  logic [7:0] pIn2, pOut2, pOe2, pull2, pIn3, pOut3, pOe3, pIn4, pOut4, pOe4;
  logic [7:0] periphEn, periphDir, periphOut, slaveOut, ext3En, ext3Val, periphIn;
  int num_errors = 0;
  int compares = 0;
  gpbcd_ports u_dut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .irq(irq),
    .secondPadIn(pIn2), .secondPadOut(pOut2), .secondPadOe(pOe2), .secondPullupEn(pull2),
    .thirdPadIn(pIn3), .thirdPadOut(pOut3), .thirdPadOe(pOe3), .fourthPadIn(pIn4),
    .fourthPadOut(pOut4), .fourthPadOe(pOe4), .periphEn(periphEn), .periphDir(periphDir),
    .periphOut(periphOut), .periphIn(periphIn), .slaveDriveEn(slaveDriveEn), .slaveOut(slaveOut),
    .slaveModeSelect(slaveModeSelect), .fourthLatch(fourthLatch),
    .externalInterruptPin(extIrqPin), .progClock(progClock), .progData(progData));
  gpbcd_pin_world u_w2 (.clk(clk), .padOut(pOut2), .padOe(pOe2), .pullEn(pull2),
    .extEn(8'hFF), .extVal(ext2Val), .padIn(pIn2));
  gpbcd_pin_world u_w3 (.clk(clk), .padOut(pOut3), .padOe(pOe3), .pullEn(8'h00),
    .extEn(ext3En), .extVal(ext3Val), .padIn(pIn3));
  gpbcd_pin_world u_w4 (.clk(clk), .padOut(pOut4), .padOe(pOe4), .pullEn(8'h00),
    .extEn(8'h00), .extVal(8'h00), .padIn(pIn4));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    logic [7:0] addrs [6] = '{ADDR_SECOND_DIR, ADDR_THIRD_DIR, ADDR_FOURTH_DIR,
      ADDR_TIMER_PULLUP_CFG, ADDR_FIFTH_DIR_SLAVE, ADDR_IRQ_MASK};
    logic [7:0] exps [6] = '{DIR_RESET, DIR_RESET, DIR_RESET, CFG_RESET, FIFTH_RESET, MASK_RESET};
    for (int i = 0; i < 6; i++) begin
      rd(addrs[i], rdv);
      chk(rdv, exps[i]);
    end
    chk(pOe2 | pOe3 | pOe4, 8'h00);
    rd(8'h55, rdv);
    chk(rdv, 8'h00);
    rd(ADDR_SECOND_DIR, rdv);
    cyc(1);
    chk(regRdData, 8'h00);
  endtask : t_reset_values
  task automatic t_drive;
    wr(ADDR_THIRD_DATA, 8'hA5);
    wr(ADDR_THIRD_DIR, 8'h0F);
    cyc(1);
    chk(pOe3, 8'hF0);
    chk(pOut3 & pOe3, 8'hA0);
    wr(ADDR_FOURTH_DATA, 8'h3C);
    wr(ADDR_FOURTH_DIR, 8'h00);
    cyc(1);
    chk(pOe4, 8'hFF);
    chk(pOut4, 8'h3C);
    rd(ADDR_FOURTH_DATA, rdv);
    chk(rdv, 8'h3C);
  endtask : t_drive
  task automatic t_override;
    wr(ADDR_THIRD_DIR, 8'hFF);
    periphEn <= 8'h05;
    periphDir <= 8'h04;
    periphOut <= 8'h01;
    cyc(1);
    chk(pOe3, 8'h01);
    chk(pOut3[0], 1'b1);
    wr(ADDR_THIRD_DIR, 8'h00);
    cyc(1);
    chk(pOe3, 8'hFB);
    periphEn <= 8'h00;
    wr(ADDR_THIRD_DIR, 8'hFF);
    ext3En <= 8'hFF;
    ext3Val <= 8'hC3;
    cyc(3);
    chk(periphIn, 8'hC3);
    rd(ADDR_THIRD_DATA, rdv);
    chk(rdv, 8'hC3);
  endtask : t_override
  task automatic t_pins_pullups;
    ext2Val <= 8'h5A;
    cyc(3);
    rd(ADDR_SECOND_DATA, rdv);
    chk(rdv, 8'h5A);
    chk(pull2, 8'h00);
    wr(ADDR_SECOND_DATA, 8'hB0);
    wr(ADDR_TIMER_PULLUP_CFG, 8'h7F);
    wr(ADDR_SECOND_DIR, 8'h0F);
    cyc(1);
    chk(pull2, 8'h0F);
    rd(ADDR_SECOND_DATA, rdv);
    chk(rdv, 8'hBA);
    wr(ADDR_SECOND_DIR, 8'hFF);
  endtask : t_pins_pullups
  task automatic t_change_irq;
    wr(ADDR_IRQ_MASK, 8'h01);
    rd(ADDR_SECOND_DATA, rdv);
    wr(ADDR_IRQ_STATUS, 8'h03);
    cyc(4);
    chk(irq, 1'b0);
    ext2Val[4] <= ~ext2Val[4];
    cyc(4);
    chk(irq, 1'b1);
    wr(ADDR_IRQ_STATUS, 8'h01);
    rd(ADDR_IRQ_STATUS, rdv);
    chk(rdv[0], 1'b1);
    rd(ADDR_SECOND_DATA, rdv);
    wr(ADDR_IRQ_STATUS, 8'h01);
    cyc(2);
    chk(irq, 1'b0);
    // pin 4 now drives a one against a zero snapshot; only the direction mask keeps the flag down
    wr(ADDR_SECOND_DIR, 8'hEF);
    ext2Val[4] <= ~ext2Val[4];
    cyc(4);
    chk(irq, 1'b0);
    wr(ADDR_SECOND_DIR, 8'hFF);
    wr(ADDR_IRQ_MASK, 8'h00);
  endtask : t_change_irq
  task automatic t_ext_irq;
    ext2Val <= 8'h40;
    cyc(3);
    wr(ADDR_IRQ_STATUS, 8'h03);
    chk({extIrqPin, progData, progClock}, 3'h1);
    ext2Val <= 8'h81;
    cyc(4);
    rd(ADDR_IRQ_STATUS, rdv);
    chk(rdv[1], 1'b1);
    chk({extIrqPin, progData, progClock}, 3'h6);
  endtask : t_ext_irq
  task automatic t_slave_and_reset;
    wr(ADDR_FIFTH_DIR_SLAVE, 8'hFF);
    rd(ADDR_FIFTH_DIR_SLAVE, rdv);
    chk(rdv, 8'h17);
    chk(slaveModeSelect, 1'b1);
    chk(fourthLatch, 8'h3C);
    slaveOut <= 8'h96;
    slaveDriveEn <= 1'b1;
    cyc(1);
    chk(pOut4 & pOe4, 8'h96);
    slaveDriveEn <= 1'b0;
    reset <= 1'b1;
    cyc(1);
    reset <= 1'b0;
    rd(ADDR_THIRD_DIR, rdv);
    chk(rdv, 8'hFF);
    chk(pOut3, 8'hA5);
    chk(fourthLatch, 8'h3C);
    rd(ADDR_IRQ_STATUS, rdv);
    chk(rdv[1], 1'b0);
  endtask : t_slave_and_reset
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(50 * 3000);
    num_errors++;
    end_sim();
  end
  initial begin
    reset = 1'b1;
    {regWrite, regRead, slaveDriveEn} = 3'h0;
    {regAddr, regWrData, periphEn, periphDir, periphOut, slaveOut} = 48'h0;
    {ext2Val, ext3En, ext3Val} = 24'h0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_reset_values();
    t_drive();
    t_override();
    t_pins_pullups();
    t_change_irq();
    t_ext_irq();
    t_slave_and_reset();
    end_sim();
  end
endmodule : tb
